/* File: hw/dmc_config_regs.sv */
// Purpose: dram / expanded-memory configuration register group and its decodes
// Assumes: io and memory cycles come from logic on core_clk, no synchronisers needed
// Notes: index selects one of three registers, data port reads or writes it
//
// Overview of operation
// - index 6bh at port 22h selects dram_config, accessed through port 23h.
// - dram_config bits 1..0 give rom wait states 0..3, reset three.
// - bits 3..2 give expanded-memory wait states, reset two, code 11 reserved.
// - bit 4 enables expanded memory, reset disabled.
// - bit 5 sets a further access wait state, reset one wait.
// - bit 6 relocates 80000h-9ffffh to 100000h-11ffffh when ram is 1 MB.
// - bit 7 enables page/interleaved dram mode, reset normal mode.
// - index 6ch selects bank23_enable through the data port.
// - bank23 bit 5 gives one bank (reset) or two banks.
// - bank23 bits 7..6 give dram type: none, reserved, 256 Kbit, 1 Mbit.
// - index 6dh selects expanded_mem_base through the data port.
// - base bits 3..0 choose the page-register i/o pair, 208h upward.
// - base bits 7..4 choose four 16 KB windows from c0000h, 4000h steps.
`timescale 1ns/100ps
module dmc_config_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_hit,
    input wire logic total_ram_1mb,
    input wire logic [23:0] mem_addr,
    output logic [1:0] rom_wait,
    output logic [1:0] ems_wait,
    output logic ems_enable,
    output logic aux_wait,
    output logic reloc_enable,
    output logic page_mode,
    output logic bank_pair,
    output logic [1:0] dram_type,
    output logic [3:0] ems_io_code,
    output logic [3:0] ems_win_code,
    output logic ems_port_hit,
    output logic ems_port_odd,
    output logic ems_win_hit,
    output logic [1:0] ems_win_page,
    output logic reloc_hit,
    output logic [23:0] phys_addr
);
    logic [7:0] index_r;
    logic [7:0] dram_config_r;
    logic [7:0] bank23_r;
    logic [7:0] ems_base_r;
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [15:0] port_base;
    logic [5:0] win_pg;
    logic [5:0] win_off;
    logic io_code_ok;
    logic win_code_ok;
    logic win_in;
    logic reloc_in;

    assign idx_wr = io_wr && (io_addr == dmc_pkg::IDX_PORT);
    assign data_wr = io_wr && (io_addr == dmc_pkg::DATA_PORT);
    assign data_rd = io_rd && (io_addr == dmc_pkg::DATA_PORT);

    // index is held until rewritten, so repeated data accesses hit the same register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            index_r <= dmc_pkg::RST_INDEX;
        end else if (idx_wr) begin
            index_r <= io_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dram_config_r <= dmc_pkg::RST_DRAM_CONFIG;
        end else if (data_wr && index_r == dmc_pkg::IDX_DRAM_CONFIG) begin
            dram_config_r <= io_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank23_r <= dmc_pkg::RST_BANK23_ENABLE;
        end else if (data_wr && index_r == dmc_pkg::IDX_BANK23_ENABLE) begin
            bank23_r <= io_wdata & dmc_pkg::BNK_WR_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ems_base_r <= dmc_pkg::RST_EXPANDED_MEM_BASE;
        end else if (data_wr && index_r == dmc_pkg::IDX_EXPANDED_MEM_BASE) begin
            ems_base_r <= io_wdata;
        end
    end

    // read data; indexes owned by other register groups leave hit low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
            io_rdata_hit <= 1'b0;
        end else if (data_rd) begin
            io_rdata_hit <= 1'b1;
            case (index_r)
                dmc_pkg::IDX_DRAM_CONFIG: io_rdata <= dram_config_r;
                dmc_pkg::IDX_BANK23_ENABLE: io_rdata <= bank23_r;
                dmc_pkg::IDX_EXPANDED_MEM_BASE: io_rdata <= ems_base_r;
                default: begin
                    io_rdata <= 8'h00;
                    io_rdata_hit <= 1'b0;
                end
            endcase
        end else begin
            io_rdata <= 8'h00;
            io_rdata_hit <= 1'b0;
        end
    end

    // field outputs copied into their own flops to keep ports straight off flip-flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rom_wait <= dmc_pkg::RST_DRAM_CONFIG[dmc_pkg::CFG_ROM_WS_LSB +: 2];
            ems_wait <= dmc_pkg::RST_DRAM_CONFIG[dmc_pkg::CFG_EMS_WS_LSB +: 2];
            ems_enable <= dmc_pkg::RST_DRAM_CONFIG[dmc_pkg::CFG_EMS_EN_BIT];
            aux_wait <= dmc_pkg::RST_DRAM_CONFIG[dmc_pkg::CFG_AUX_WS_BIT];
            reloc_enable <= 1'b0;
            page_mode <= dmc_pkg::RST_DRAM_CONFIG[dmc_pkg::CFG_PAGE_BIT];
        end else begin
            rom_wait <= dram_config_r[dmc_pkg::CFG_ROM_WS_LSB +: 2];
            ems_wait <= dram_config_r[dmc_pkg::CFG_EMS_WS_LSB +: 2];
            ems_enable <= dram_config_r[dmc_pkg::CFG_EMS_EN_BIT];
            aux_wait <= dram_config_r[dmc_pkg::CFG_AUX_WS_BIT];
            reloc_enable <= dram_config_r[dmc_pkg::CFG_RELOC_BIT] && total_ram_1mb;
            page_mode <= dram_config_r[dmc_pkg::CFG_PAGE_BIT];
        end
    end

    // bank fields; reserved low bits never reach a port
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank_pair <= dmc_pkg::RST_BANK23_ENABLE[dmc_pkg::BNK_PAIR_BIT];
            dram_type <= dmc_pkg::RST_BANK23_ENABLE[dmc_pkg::BNK_TYPE_LSB +: 2];
        end else begin
            bank_pair <= bank23_r[dmc_pkg::BNK_PAIR_BIT];
            dram_type <= bank23_r[dmc_pkg::BNK_TYPE_LSB +: 2];
        end
    end

    // base fields pass reserved codes through; the decodes below refuse them
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ems_io_code <= dmc_pkg::RST_EXPANDED_MEM_BASE[dmc_pkg::EMB_IO_LSB +: 4];
            ems_win_code <= dmc_pkg::RST_EXPANDED_MEM_BASE[dmc_pkg::EMB_WIN_LSB +: 4];
        end else begin
            ems_io_code <= ems_base_r[dmc_pkg::EMB_IO_LSB +: 4];
            ems_win_code <= ems_base_r[dmc_pkg::EMB_WIN_LSB +: 4];
        end
    end

    // page-register port pair: base + code * 10h, only listed codes decode
    assign port_base = dmc_pkg::EMS_IO_BASE
        + (dmc_pkg::EMS_IO_STEP * {12'h000, ems_base_r[dmc_pkg::EMB_IO_LSB +: 4]});
    assign io_code_ok = dmc_pkg::EMS_IO_VALID[ems_base_r[dmc_pkg::EMB_IO_LSB +: 4]];

    // window: code selects first 16 KB page, four consecutive pages follow
    assign win_pg = dmc_pkg::EMS_WIN_PG_BASE + {2'b00, ems_base_r[dmc_pkg::EMB_WIN_LSB +: 4]};
    assign win_code_ok = ems_base_r[dmc_pkg::EMB_WIN_LSB +: 4] <= dmc_pkg::EMS_WIN_MAX_CODE;
    assign win_off = mem_addr[19:14] - win_pg;
    assign win_in = (mem_addr[23:20] == 4'h0) && (mem_addr[19:14] >= win_pg) && (win_off < 6'h04);
    assign reloc_in = mem_addr[23:17] == dmc_pkg::RELOC_HI_BLOCK;

    // decodes are one cycle behind io_addr / mem_addr; a trade for flop-driven outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ems_port_hit <= 1'b0;
            ems_port_odd <= 1'b0;
        end else begin
            ems_port_hit <= dram_config_r[dmc_pkg::CFG_EMS_EN_BIT] && io_code_ok
                && (io_addr[15:1] == port_base[15:1]);
            ems_port_odd <= io_addr[0];
        end
    end

    // page index is only meaningful while the window hit is high
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ems_win_hit <= 1'b0;
            ems_win_page <= 2'b00;
        end else begin
            ems_win_hit <= dram_config_r[dmc_pkg::CFG_EMS_EN_BIT] && win_code_ok && win_in;
            ems_win_page <= win_off[1:0];
        end
    end

    // relocated block: accesses at 100000h-11ffffh land on 080000h-09ffffh
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reloc_hit <= 1'b0;
        end else begin
            reloc_hit <= dram_config_r[dmc_pkg::CFG_RELOC_BIT] && total_ram_1mb && reloc_in;
        end
    end

    // unrelocated addresses pass straight through, one cycle late like the hit
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phys_addr <= 24'h000000;
        end else begin
            if (dram_config_r[dmc_pkg::CFG_RELOC_BIT] && total_ram_1mb && reloc_in) begin
                phys_addr <= mem_addr - dmc_pkg::RELOC_OFFSET;
            end else begin
                phys_addr <= mem_addr;
            end
        end
    end
endmodule // dmc_config_regs

/* File: hw/dmc_pkg.sv */
// Purpose: constants for the memory-controller configuration register group
// Assumes: 8-bit index/data port pair on the system i/o space
// Notes: offsets are register indexes written to the index port
package dmc_pkg;
    localparam logic [15:0] IDX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    localparam logic [7:0] IDX_DRAM_CONFIG = 8'h6b;
    localparam logic [7:0] IDX_BANK23_ENABLE = 8'h6c;
    localparam logic [7:0] IDX_EXPANDED_MEM_BASE = 8'h6d;
    localparam logic [7:0] RST_DRAM_CONFIG = 8'h6b;
    localparam logic [7:0] RST_BANK23_ENABLE = 8'h00;
    localparam logic [7:0] RST_EXPANDED_MEM_BASE = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    // dram_config fields
    localparam int CFG_ROM_WS_LSB = 0;
    localparam int CFG_EMS_WS_LSB = 2;
    localparam int CFG_EMS_EN_BIT = 4;
    localparam int CFG_AUX_WS_BIT = 5;
    localparam int CFG_RELOC_BIT = 6;
    localparam int CFG_PAGE_BIT = 7;
    // bank23_enable fields
    localparam int BNK_PAIR_BIT = 5;
    localparam int BNK_TYPE_LSB = 6;
    localparam logic [7:0] BNK_WR_MASK = 8'he0;
    // expanded_mem_base fields
    localparam int EMB_IO_LSB = 0;
    localparam int EMB_WIN_LSB = 4;
    // page-register i/o pair: base + code * step
    localparam logic [15:0] EMS_IO_BASE = 16'h0208;
    localparam logic [15:0] EMS_IO_STEP = 16'h0010;
    localparam logic [15:0] EMS_IO_VALID = 16'h4c63;
    // window: 16 KB pages from c0000h, four consecutive pages
    localparam logic [5:0] EMS_WIN_PG_BASE = 6'h30;
    localparam logic [3:0] EMS_WIN_MAX_CODE = 4'h8;
    // relocation 080000h-09ffffh seen at 100000h-11ffffh
    localparam logic [6:0] RELOC_HI_BLOCK = 7'h08;
    localparam logic [23:0] RELOC_OFFSET = 24'h080000;
endpackage

/* File: sim/dmc_checker.sv */
// Purpose: port checks for dmc_config_regs
// Assumes: index and dram_config copies kept here
// Notes: read-back, reloc and phys-address checks skip the edge after reset
`timescale 1ns/100ps
module dmc_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_hit,
    input wire logic total_ram_1mb,
    input wire logic [23:0] mem_addr,
    input wire logic [1:0] rom_wait,
    input wire logic [1:0] ems_wait,
    input wire logic ems_enable,
    input wire logic aux_wait,
    input wire logic page_mode,
    input wire logic ems_win_hit,
    input wire logic reloc_hit,
    input wire logic [23:0] phys_addr
);
    logic [7:0] idx_r;
    logic [7:0] cfg_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idx_r <= 8'h00;
            cfg_r <= 8'h6b;
        end else if (io_wr && io_addr == 16'h0022) idx_r <= io_wdata;
        else if (io_wr && io_addr == 16'h0023 && idx_r == 8'h6b) cfg_r <= io_wdata;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_rdata_zero: assert property (!io_rdata_hit |-> io_rdata == 8'h00) else $error("idle read data");
    a_hit_cause: assert property (io_rdata_hit |-> $past(io_rd) && $past(io_addr) == 16'h0023
        && $past(idx_r) inside {[8'h6b:8'h6d]}) else $error("read hit without cause");
    a_read_back: assert property ($past(rst_n) && $past(io_rd && io_addr == 16'h0023 && idx_r == 8'h6b)
        |-> io_rdata_hit && io_rdata == $past(cfg_r)) else $error("config read back");
    a_cfg_fields: assert property ({page_mode, aux_wait, ems_enable, ems_wait, rom_wait}
        == $past({cfg_r[7], cfg_r[5:0]})) else $error("config field copy");
    a_reloc_hit: assert property ($past(rst_n) |-> reloc_hit
        == $past(cfg_r[6] && total_ram_1mb && mem_addr[23:17] == 7'h08)) else $error("reloc decode");
    a_phys_addr: assert property ($past(rst_n) |-> phys_addr
        == (reloc_hit ? $past(mem_addr) - 24'h080000 : $past(mem_addr))) else $error("phys address");
    a_win_off: assert property (ems_win_hit |-> $past(cfg_r[4])) else $error("window hit disabled");
    a_win_range: assert property (ems_win_hit |-> $past(mem_addr[23:16]) inside {[8'h0c:8'h0e]})
        else $error("window hit out of range");
endmodule // dmc_checker

/* File: sim/dmc_config_regs_tb.sv */
// Purpose: self-checking bench for dmc_config_regs
// Assumes: one io access at a time, read data one edge later
// Notes: rows hold index, write value, hit and read-back
`timescale 1ns/100ps
module dmc_config_regs_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic total_ram_1mb = 1'b1;
    logic [23:0] mem_addr = 24'h000000;
    logic [7:0] io_rdata;
    logic io_rdata_hit, ems_enable, aux_wait, reloc_enable, page_mode, bank_pair, ems_port_hit, ems_port_odd;
    logic ems_win_hit, reloc_hit;
    logic [1:0] rom_wait, ems_wait, dram_type, ems_win_page;
    logic [3:0] ems_io_code, ems_win_code;
    logic [23:0] phys_addr;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [24:0] rows [4] = '{{8'h6b, 8'ha5, 9'h1a5}, {8'h6c, 8'hff, 9'h1e0}, {8'h6d, 8'h5a, 9'h15a}, {8'h6a, 8'hff, 9'h000}};
    dmc_config_regs dmc_config_regs_inst (.*);
    initial forever #20 core_clk = ~core_clk;
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic io(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= w;
        io_rd <= !w;
        @(posedge core_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        io(16'h0022, i, 1'b1);
        io(16'h0023, d, 1'b1);
    endtask
    task automatic rreg(input logic [7:0] i);
        io(16'h0022, i, 1'b1);
        io(16'h0023, 8'h00, 1'b0);
        #1;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        chk({page_mode, reloc_enable, aux_wait, ems_enable, ems_wait, rom_wait}, 8'h6b);
        chk({dram_type, bank_pair, ems_win_code, ems_io_code}, 11'h000);
        rreg(8'h6b);
        chk(io_rdata, 8'h6b);
        foreach (rows[i]) begin
            wreg(rows[i][24:17], rows[i][16:9]);
            rreg(rows[i][24:17]);
            chk({io_rdata_hit, io_rdata}, rows[i][8:0]);
        end
        tick(1);
        chk(io_rdata_hit, 1'b0);
        wreg(8'h6c, 8'hc0);
        wreg(8'h6b, 8'h10);
        wreg(8'h6d, 8'h21);
        chk({dram_type, bank_pair}, 3'h6);
        @(posedge core_clk) mem_addr <= 24'h0d0000;
        io(16'h0219, 8'h00, 1'b0);
        #1;
        chk({page_mode, reloc_enable, aux_wait, ems_enable, ems_wait, rom_wait}, 8'h10);
        chk({ems_win_code, ems_io_code, ems_port_hit, ems_port_odd, ems_win_hit, ems_win_page}, 13'h043e);
        wreg(8'h6b, 8'h40);
        io(16'h0219, 8'h00, 1'b0);
        mem_addr <= 24'h100040;
        tick(1);
        chk({ems_port_hit, ems_win_hit, reloc_hit, phys_addr}, 27'h1080040);
        total_ram_1mb <= 1'b0;
        tick(2);
        chk({reloc_enable, reloc_hit, phys_addr}, 26'h0100040);
        @(posedge core_clk) rst_n <= 1'b0;
        tick(2);
        @(posedge core_clk) rst_n <= 1'b1;
        rreg(8'h6d);
        chk({io_rdata_hit, io_rdata}, 9'h100);
        summarize();
    end
endmodule // dmc_config_regs_tb
bind dmc_config_regs dmc_checker dmc_checker_inst (.*);
